// *** lps_params.svh ***
/*
  Constants of the pixel link serializer: lane layout,
  slot counts, buffer depth and timing counts.
  Assumes a system clock of 20 MHz.
*/
`ifndef LPS_PARAMS_SVH
`define LPS_PARAMS_SVH

// ------------------------------------------------
// Link layout
// ------------------------------------------------
`define LPS_WORD_W 21
`define LPS_COLOR_W 18
`define LPS_LANES 3
`define LPS_SLOTS 7
`define LPS_SLOT_W 3
`define LPS_LAST_SLOT 3'h6
`define LPS_CLK_PATTERN 7'h63
`define LPS_FIFO_DEPTH 32

// ------------------------------------------------
// Timing
// ------------------------------------------------
`define LPS_CLK_NS 50
`define LPS_PD_DELAY_NS 100
`define LPS_PD_DELAY_CYC (`LPS_PD_DELAY_NS / `LPS_CLK_NS)
`define LPS_LOCK_MS 10
`define LPS_LOCK_CYC (`LPS_LOCK_MS * 1000000 / `LPS_CLK_NS)
`define LPS_LOCK_W 18

`endif

// *** lps_pkg.sv ***
/*
  Types of the pixel link serializer.
  Assumes lps_params.svh for the widths.
*/
`include "lps_params.svh"

package lps_pkg;

  // ------------------------------------------------
  // One pixel word as carried over the link
  // ------------------------------------------------
  typedef struct packed {
    logic pixel_valid;
    logic frame_sync;
    logic line_sync;
    logic [`LPS_COLOR_W-1:0] color;
  } lps_pixel_s;

  typedef logic [`LPS_SLOT_W-1:0] lps_slot_t;

endpackage

// *** lps_serializer.sv ***
/*
  Pixel link serializer: transmit path from host pins to
  three data lanes plus a clock lane, buffered by a FIFO,
  and receive path from the lanes back to parallel pixels.
  Assumes clk at 20 MHz, rst synchronous to clk, and a
  free-running bit clock on link_clk for the receive lanes.
*/
`timescale 1ns/100ps
`include "lps_params.svh"

// ------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------
module lps_fifo #(
  parameter int W = `LPS_WORD_W,
  parameter int D = `LPS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full and empty flags from the fill count; the
  // count is one bit wider than the pointers
  assign in_ready = (cnt_reg != (AW + 1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// Functional notes
// R01: Capture one 21-bit word per pixel clock
// R02: Split each word over three data lanes
// R03: Send clock copy on a fourth lane
// R04: Seven bit slots per lane per period
// R05: Word is 18 colour plus three syncs
// R06: Receiver rebuilds 21 bits per clock
// R07: Strobe pin selects rising or falling edge
// R08: Receiver data stable at output falling edge
// R09: Host pixel clock between 20 and 65 MHz; the code samples it on the 20 MHz clk and drains one word per 7 cycles
// R10: Power-down input stops link activity
// R11: Slots zero to six in fixed order
// R12: User waits for lock before trusting data
// R13: Transmitter powers down within 100 ns
// R14: Power-down floats lanes, zeroes receiver outputs
module lps_serializer #(
  parameter int unsigned LOCK_CYC = `LPS_LOCK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic tx_pixel_clock_in,
  input wire logic tx_strobe_rise,
  input wire logic tx_pd_n,
  input wire lps_pkg::lps_pixel_s tx_pixel,
  output logic tx_fifo_ready,
  output logic [`LPS_LANES-1:0] tx_lane_out,
  output logic tx_clk_lane_out,
  output logic tx_lane_oe,
  output logic tx_locked,
  input wire logic [`LPS_LANES-1:0] rx_lane_in,
  input wire logic rx_clk_lane_in,
  input wire logic rx_pd_n,
  output lps_pkg::lps_pixel_s rx_pixel,
  output logic rx_pixel_clock_out
);

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------

  // Bits of one slot, lane l carries word bits l*7..l*7+6
  function automatic logic [`LPS_LANES-1:0] slot_bits(
    input logic [`LPS_WORD_W-1:0] w,
    input lps_pkg::lps_slot_t s
  );
    logic [`LPS_LANES-1:0] b;
    b = '0;
    for (int l = 0; l < `LPS_LANES; l++) begin
      b[l] = w[l * `LPS_SLOTS + int'(s)];
    end
    return b;
  endfunction

  // Next slot number, wrapping after slot six
  function automatic lps_pkg::lps_slot_t slot_inc(
    input lps_pkg::lps_slot_t s
  );
    return (s == `LPS_LAST_SLOT) ? '0 : s + 1'b1;
  endfunction

  // ------------------------------------------------
  // Transmit pin synchronisers
  // ------------------------------------------------
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic pclk_s3_reg;
  lps_pkg::lps_pixel_s data_s1_reg;
  lps_pkg::lps_pixel_s data_s2_reg;

  // Two flops on every host pin; the pixel clock bits
  // keep tracking in reset so no false edge follows it
  always_ff @(posedge clk) begin
    pin_s1_reg[0] <= tx_pixel_clock_in;
    pin_s2_reg[0] <= pin_s1_reg[0];
    pclk_s3_reg <= pin_s2_reg[0];
    if (rst) begin
      pin_s1_reg[2:1] <= 2'h0;
      pin_s2_reg[2:1] <= 2'h0;
    end else begin
      pin_s1_reg[2:1] <= {tx_pd_n, tx_strobe_rise};
      pin_s2_reg[2:1] <= pin_s1_reg[2:1];
    end
  end

  // Data pins follow the same two-flop path
  always_ff @(posedge clk) begin
    data_s1_reg <= tx_pixel;
    data_s2_reg <= data_s1_reg;
  end

  // ------------------------------------------------
  // Transmit capture
  // ------------------------------------------------
  wire pclk_s = pin_s2_reg[0];
  wire strobe_rise = pin_s2_reg[1];
  wire tx_run = pin_s2_reg[2];
  wire pclk_rise = pclk_s && !pclk_s3_reg;
  wire pclk_fall = !pclk_s && pclk_s3_reg;
  // Strobe pin picks the capture edge [R07]
  wire cap_edge = strobe_rise ? pclk_rise : pclk_fall;
  // One word per pixel clock, none in power-down [R01] [R10]
  wire cap_valid = cap_edge && tx_run;

  // ------------------------------------------------
  // Transmit buffer
  // ------------------------------------------------
  logic [`LPS_WORD_W-1:0] fifo_out;
  logic fifo_out_valid;
  lps_pkg::lps_slot_t slot_reg;
  wire slot_last = (slot_reg == `LPS_LAST_SLOT);

  // Drain only at the end of a pixel period
  lps_fifo #(
    .W(`LPS_WORD_W),
    .D(`LPS_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(data_s2_reg),
    .in_valid(cap_valid),
    .in_ready(tx_fifo_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(slot_last)
  );

  // ------------------------------------------------
  // Transmit serializer
  // ------------------------------------------------
  logic [`LPS_WORD_W-1:0] tx_word_reg;
  logic [`LPS_LANES-1:0] lane_reg;
  logic clk_lane_reg;

  // Next word; an empty buffer sends an idle word
  wire [`LPS_WORD_W-1:0] word_next =
    fifo_out_valid ? fifo_out : '0;
  wire lps_pkg::lps_slot_t slot_next = slot_inc(slot_reg);

  // Slot counter and word holding [R04] [R11]
  always_ff @(posedge clk) begin
    if (rst) begin
      slot_reg <= `LPS_LAST_SLOT;
      tx_word_reg <= '0;
    end else begin
      slot_reg <= slot_next;
      if (slot_last) begin
        tx_word_reg <= word_next;
      end
    end
  end

  // Lane bits in slot order [R02] [R11]
  wire [`LPS_LANES-1:0] lane_next = slot_last ?
    slot_bits(word_next, slot_next) :
    slot_bits(tx_word_reg, slot_next);
  wire [`LPS_SLOTS-1:0] clk_pattern = `LPS_CLK_PATTERN;
  // Clock lane pattern 1100011 per period [R03]
  wire clk_lane_next = clk_pattern[slot_next];

  // Lane output flops
  always_ff @(posedge clk) begin
    if (rst) begin
      lane_reg <= '0;
      clk_lane_reg <= 1'b0;
    end else begin
      lane_reg <= lane_next;
      clk_lane_reg <= clk_lane_next;
    end
  end

  assign tx_lane_out = lane_reg;
  assign tx_clk_lane_out = clk_lane_reg;
  // Float all lanes two edges after power-down [R13] [R14]
  assign tx_lane_oe = tx_run;

  // ------------------------------------------------
  // Transmit lock timer
  // ------------------------------------------------
  logic [`LPS_LOCK_W-1:0] lock_reg;
  logic locked_reg;

  // Restart lock wait after power-down release [R12]
  always_ff @(posedge clk) begin
    if (rst || !tx_run) begin
      lock_reg <= '0;
      locked_reg <= 1'b0;
    end else if (lock_reg == `LPS_LOCK_W'(LOCK_CYC - 1)) begin
      locked_reg <= 1'b1;
    end else begin
      lock_reg <= lock_reg + 1'b1;
    end
  end

  assign tx_locked = locked_reg;

  // ------------------------------------------------
  // Receive reset and lane synchronisers
  // ------------------------------------------------
  logic lrst_s1_reg;
  logic lrst_s2_reg;
  logic [`LPS_LANES:0] lane_s1_reg;
  logic [`LPS_LANES:0] lane_s2_reg;

  // Reset carried into the link domain
  always_ff @(posedge link_clk) begin
    lrst_s1_reg <= rst;
    lrst_s2_reg <= lrst_s1_reg;
  end

  // Two flops on the lane pins
  always_ff @(posedge link_clk) begin
    if (lrst_s2_reg) begin
      lane_s1_reg <= '0;
      lane_s2_reg <= '0;
    end else begin
      lane_s1_reg <= {rx_clk_lane_in, rx_lane_in};
      lane_s2_reg <= lane_s1_reg;
    end
  end

  // ------------------------------------------------
  // Receive deserializer
  // ------------------------------------------------
  logic clk_prev_reg;
  lps_pkg::lps_slot_t pos_reg;
  logic [`LPS_WORD_W-1:0] acc_reg;
  logic [`LPS_WORD_W-1:0] hold_reg;
  logic done_reg;
  logic tog_reg;
  wire rx_clk_bit = lane_s2_reg[`LPS_LANES];
  // Clock lane rise marks slot zero
  wire frame_start = rx_clk_bit && !clk_prev_reg;
  wire lps_pkg::lps_slot_t pos =
    frame_start ? '0 : slot_inc(pos_reg);

  // Slot tracking against the clock lane [R06]
  always_ff @(posedge link_clk) begin
    if (lrst_s2_reg) begin
      clk_prev_reg <= 1'b0;
      pos_reg <= `LPS_LAST_SLOT;
      done_reg <= 1'b0;
    end else begin
      clk_prev_reg <= rx_clk_bit;
      pos_reg <= pos;
      done_reg <= (pos == `LPS_LAST_SLOT);
    end
  end

  // Place each lane bit at its word position [R06]
  always_ff @(posedge link_clk) begin
    for (int l = 0; l < `LPS_LANES; l++) begin
      acc_reg[l * `LPS_SLOTS + int'(pos)] <= lane_s2_reg[l];
    end
  end

  // Publish a whole word with a toggle
  always_ff @(posedge link_clk) begin
    if (lrst_s2_reg) begin
      hold_reg <= '0;
      tog_reg <= 1'b0;
    end else if (done_reg) begin
      hold_reg <= acc_reg;
      tog_reg <= !tog_reg;
    end
  end

  // ------------------------------------------------
  // Receive crossing into clk
  // ------------------------------------------------
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic rpd_s1_reg;
  logic rpd_s2_reg;

  // Toggle and power-down pin synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
      rpd_s1_reg <= 1'b0;
      rpd_s2_reg <= 1'b0;
    end else begin
      tog_s1_reg <= tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
      rpd_s1_reg <= rx_pd_n;
      rpd_s2_reg <= rpd_s1_reg;
    end
  end

  wire rx_run = rpd_s2_reg;
  wire word_arrived = tog_s2_reg ^ tog_s3_reg;

  // ------------------------------------------------
  // Receive parallel outputs
  // ------------------------------------------------
  lps_pkg::lps_pixel_s rx_pixel_reg;
  logic rx_pclk_reg;

  // New word and clock high together; the falling
  // edge one cycle later meets stable data [R08]
  always_ff @(posedge clk) begin
    if (rst || !rx_run) begin
      rx_pixel_reg <= '0; // Outputs low in power-down [R14] [R10]
      rx_pclk_reg <= 1'b0;
    end else if (word_arrived) begin
      rx_pixel_reg <= hold_reg; // Colour and syncs [R05] [R06]
      rx_pclk_reg <= 1'b1;
    end else begin
      rx_pclk_reg <= 1'b0;
    end
  end

  assign rx_pixel = rx_pixel_reg;
  assign rx_pixel_clock_out = rx_pclk_reg;

endmodule

// *** lps_checker.sv ***
/*
  Assertions on the ports of the pixel link serializer.
  Assumes binding to lps_serializer, one clk domain.
*/
`timescale 1ns/100ps
module lps_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_pd_n,
  input wire logic tx_clk_lane_out,
  input wire logic tx_lane_oe,
  input wire logic tx_locked,
  input wire logic rx_pd_n,
  input wire lps_pkg::lps_pixel_s rx_pixel,
  input wire logic rx_pixel_clock_out
);
  // ----------------------------------------
  // Properties on transmit and receive
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Clock lane low and high runs
  sequence s_lo3;
    !tx_clk_lane_out [*3];
  endsequence
  sequence s_hi4;
    tx_clk_lane_out [*4];
  endsequence
  property p_clk_lane;
    disable iff (rst || !tx_lane_oe)
    $fell(tx_clk_lane_out) |-> s_lo3 ##1 s_hi4 ##1 !tx_clk_lane_out;
  endproperty
  property p_pd_oe;
    $fell(tx_pd_n) |-> ##[0:2] !tx_lane_oe;
  endproperty
  property p_pd_hold;
    (!tx_pd_n) [*4] |-> !tx_lane_oe && !tx_locked;
  endproperty
  property p_oe_rise;
    $rose(tx_lane_oe) |-> $past(tx_pd_n, 2);
  endproperty
  property p_lock;
    $rose(tx_locked) |-> tx_lane_oe && $past(tx_lane_oe, 8);
  endproperty
  property p_rx_pd;
    (!rx_pd_n) [*4] |-> rx_pixel == '0 && !rx_pixel_clock_out;
  endproperty
  property p_rx_pulse;
    $rose(rx_pixel_clock_out) |=> !rx_pixel_clock_out;
  endproperty
  property p_rx_stable;
    $changed(rx_pixel) |-> rx_pixel_clock_out || !rx_pd_n;
  endproperty
  a_clk_lane: assert property (p_clk_lane) else $error("clock lane pattern wrong");
  a_pd_oe: assert property (p_pd_oe) else $error("power-down entry too slow");
  a_pd_hold: assert property (p_pd_hold) else $error("lanes driven in power-down");
  a_oe_rise: assert property (p_oe_rise) else $error("lanes enabled without pin");
  a_lock: assert property (p_lock) else $error("lock rose too early");
  a_rx_pd: assert property (p_rx_pd) else $error("receiver outputs not low");
  a_rx_pulse: assert property (p_rx_pulse) else $error("output clock pulse too long");
  a_rx_stable: assert property (p_rx_stable) else $error("pixel changed without clock");
endmodule

bind lps_serializer lps_checker u_chk (.clk(clk), .rst(rst), .tx_pd_n(tx_pd_n),
  .tx_clk_lane_out(tx_clk_lane_out), .tx_lane_oe(tx_lane_oe), .tx_locked(tx_locked),
  .rx_pd_n(rx_pd_n), .rx_pixel(rx_pixel), .rx_pixel_clock_out(rx_pixel_clock_out));

// *** lps_host_model.sv ***
/*
  Far-side models: host pixel source and link sender.
  Assumes the bench calls the tasks at falling clk edges.
*/
`timescale 1ns/100ps
module lps_host_model (
  input wire logic clk,
  input wire logic link_clk,
  output logic pclk,
  output lps_pkg::lps_pixel_s pix,
  output logic [2:0] lane,
  output logic clk_lane
);
  // ----------------------------------------
  // Host side and link side
  // ----------------------------------------
  lps_pkg::lps_pixel_s lq[$];
  lps_pkg::lps_pixel_s cur = '0;
  int slot = 0;
  initial begin
    pclk = 1'b0;
    pix = '0;
    lane = 3'h0;
    clk_lane = 1'b0;
  end
  // Word first, then strobe edge, then back to idle
  task automatic send(input lps_pkg::lps_pixel_s w, input int ph);
    @(negedge clk);
    pix = w;
    repeat (ph) @(negedge clk);
    pclk = ~pclk;
    repeat (ph) @(negedge clk);
    pclk = ~pclk;
  endtask
  task automatic set_idle(input logic v);
    @(negedge clk);
    pclk = v;
  endtask
  task automatic link_send(input lps_pkg::lps_pixel_s w);
    lq.push_back(w);
  endtask
  // Slot 0 marked by clock lane rise; idle sends zero words
  always @(negedge link_clk) begin
    if (slot == 0)
      cur = (lq.size() > 0) ? lq.pop_front() : '0;
    for (int l = 0; l < 3; l++)
      lane[l] = cur[l * 7 + slot];
    clk_lane = slot < 4;
    slot = (slot + 1) % 7;
  end
endmodule

// *** tb_lps_serializer.sv ***
/*
  Testbench of the pixel link serializer.
  Assumes lps_host_model on the far side of both paths.
*/
`timescale 1ns/100ps
module tb_lps_serializer;
  // ----------------------------------------
  // Clocks, models and device
  // ----------------------------------------
  logic clk, rst, link_clk, strobe, tx_pd_n, rx_pd_n, full_seen;
  logic pclk, clk_lane, fifo_rdy, ck_out, oe, locked, tx_ck;
  logic [2:0] lane, tx_lane;
  logic [6:0] hist = 7'h0;
  logic [6:0] sh [3];
  logic [20:0] dw;
  lps_pkg::lps_pixel_s pix, rx_pix;
  lps_pkg::lps_pixel_s txq[$];
  lps_pkg::lps_pixel_s rxq[$];
  int n_tests = 0;
  int n_mismatch = 0;
  int cyc = 0;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  lps_host_model host (.clk(clk), .link_clk(link_clk), .pclk(pclk), .pix(pix), .lane(lane),
    .clk_lane(clk_lane));
  lps_serializer #(.LOCK_CYC(16)) dut (.clk(clk), .rst(rst), .link_clk(link_clk),
    .tx_pixel_clock_in(pclk), .tx_strobe_rise(strobe), .tx_pd_n(tx_pd_n), .tx_pixel(pix),
    .tx_fifo_ready(fifo_rdy), .tx_lane_out(tx_lane), .tx_clk_lane_out(tx_ck), .tx_lane_oe(oe),
    .tx_locked(locked), .rx_lane_in(lane), .rx_clk_lane_in(clk_lane), .rx_pd_n(rx_pd_n),
    .rx_pixel(rx_pix), .rx_pixel_clock_out(ck_out));
  // Lane decoder, receive capture, timeout
  always @(posedge clk) begin
    hist <= {hist[5:0], tx_ck};
    for (int l = 0; l < 3; l++)
      sh[l] <= {sh[l][5:0], tx_lane[l]};
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end
  always @(negedge clk) begin
    if (fifo_rdy === 1'b0)
      full_seen = 1'b1;
    if (ck_out === 1'b1 && rx_pix !== '0)
      rxq.push_back(rx_pix);
    if (hist === 7'h63 && oe === 1'b1) begin
      for (int b = 0; b < 21; b++)
        dw[b] = sh[b / 7][6 - b % 7];
      if (dw !== 21'h0)
        txq.push_back(dw);
    end
  end
  // ----------------------------------------
  // Checks and scenarios
  // ----------------------------------------
  function automatic logic [20:0] mk(input int i);
    return {1'b1, 2'(i), 18'h15a5a + 18'(i * 37)};
  endfunction
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic t_tx;
    for (int m = 1; m >= 0; m--) begin
      strobe = m[0];
      repeat (4) @(negedge clk);
      host.set_idle(~m[0]);
      repeat (4) @(negedge clk);
      txq.delete();
      for (int i = 0; i < 4; i++)
        host.send(mk(4 * m + i), 4);
      for (int k = 0; k < 200 && txq.size() < 4; k++)
        @(negedge clk);
      for (int i = 0; i < 4; i++)
        chk(txq[i], mk(4 * m + i));
    end
    $display("done t_tx");
  endtask
  task automatic t_rx;
    rxq.delete();
    for (int i = 0; i < 4; i++)
      host.link_send(mk(20 + i));
    for (int k = 0; k < 400 && rxq.size() < 4; k++)
      @(negedge clk);
    for (int i = 0; i < 4; i++)
      chk(rxq[i], mk(20 + i));
    $display("done t_rx");
  endtask
  task automatic t_pd;
    tx_pd_n = 1'b0;
    rx_pd_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(21'(oe), 21'h0);
    txq.delete();
    host.send(mk(30), 4);
    host.link_send(mk(31));
    repeat (60) @(negedge clk);
    chk(rx_pix, 21'h0);
    tx_pd_n = 1'b1;
    rx_pd_n = 1'b1;
    repeat (10) @(negedge clk);
    chk(21'(locked), 21'h0);
    repeat (12) @(negedge clk);
    chk(21'({locked, oe}), 21'h3);
    chk(21'(txq.size()), 21'h0);
    $display("done t_pd");
  endtask
  task automatic t_fill;
    full_seen = 1'b0;
    txq.delete();
    for (int i = 0; i < 130; i++)
      host.send(mk(40 + i), 2);
    repeat (300) @(negedge clk);
    chk(21'(full_seen), 21'h1);
    chk(21'(txq.size() < 130), 21'h1);
    for (int i = 0; i < 40; i++)
      chk(txq[i], mk(40 + i));
    chk(21'(fifo_rdy), 21'h1);
    $display("done t_fill");
  endtask
  task automatic give_verdict;
    $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    strobe = 1'b1;
    tx_pd_n = 1'b1;
    rx_pd_n = 1'b1;
    full_seen = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (30) @(negedge clk);
    t_tx();
    t_rx();
    t_pd();
    t_fill();
    give_verdict();
  end
endmodule
